// ===== pkg/osc_pkg.sv
package osc_pkg;
  // Register byte offsets
  localparam logic [7:0] SCC_OFF = 8'h00;
  localparam logic [7:0] RC_OFF = 8'h04;
  localparam logic [7:0] HX_OFF = 8'h08;
  localparam logic [7:0] LX_OFF = 8'h0C;
  localparam logic [7:0] ST_OFF = 8'h10;
  localparam int ADDR_W = 8;
  // Field positions
  localparam int SEL_LSB = 5;
  localparam int SEL_W = 3;
  localparam int FHS_B = 3;
  localparam int FSS_B = 2;
  localparam int FHID_B = 1;
  localparam int FSID_B = 0;
  localparam int RC_FREQ_LSB = 2;
  localparam int RC_FREQ_W = 2;
  localparam int RC_FLAG_B = 1;
  localparam int RC_EN_B = 0;
  localparam int HX_MODE_B = 2;
  localparam int HX_FLAG_B = 1;
  localparam int HX_EN_B = 0;
  localparam int LX_FLAG_B = 1;
  localparam int LX_EN_B = 0;
  localparam int PDF_B = 0;
  localparam int TO_B = 1;
  localparam int MODE_LSB = 4;
  // Reset values
  localparam logic [7:0] SCC_RST = 8'h00;
  localparam logic [7:0] RC_RST = 8'h01;
  localparam logic [7:0] HX_RST = 8'h00;
  localparam logic [7:0] LX_RST = 8'h00;
  localparam logic [2:0] SEL_SUB = 3'h7;
  // Oscillator indices for the settle timers
  localparam int OSC_RC = 0;
  localparam int OSC_HX = 1;
  localparam int OSC_LX = 2;
  localparam int N_OSC = 3;
  // Timing
  localparam int CLK_NS = 8;
  localparam int RC_SETTLE_NS = 800;
  localparam int HX_SETTLE_NS = 2000;
  localparam int LX_SETTLE_NS = 4000;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] RC_CYC = CNT_W'((RC_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] HX_CYC = CNT_W'((HX_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] LX_CYC = CNT_W'((LX_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [N_OSC-1:0][CNT_W-1:0] SETTLE_CYC = {LX_CYC, HX_CYC, RC_CYC};
  localparam int DIV_W = 6;

  typedef enum logic [2:0] {
    MODE_FAST = 3'h0, MODE_SLOW = 3'h1, MODE_IDLE0 = 3'h3,
    MODE_IDLE1 = 3'h2, MODE_IDLE2 = 3'h6, MODE_SLEEP = 3'h4
  } mode_t;

  typedef enum logic [1:0] {SW_RUN = 2'h0, SW_DRAIN = 2'h1, SW_ARM = 2'h3} sw_t;
endpackage

// ===== pkg/clk_sel_if.sv
`timescale 1ns/10ps
interface clk_sel_if;
  logic want_sub;
  logic [2:0] div_code;
  logic sub_tick;
  logic run_fast;
  logic run_sub;
  logic sys_en;
  logic on_sub;
  modport ctrl (output want_sub, div_code, sub_tick, run_fast, run_sub,
                input sys_en, on_sub);
  modport sw (input want_sub, div_code, sub_tick, run_fast, run_sub,
              output sys_en, on_sub);
endinterface

// ===== rtl/clk_switch.sv
`timescale 1ns/10ps
module clk_switch (
  input wire logic hclk,
  input wire logic hresetn,
  clk_sel_if.sw bus
);
  import osc_pkg::*;

  typedef struct packed {
    sw_t state;
    logic on_sub;
    logic [2:0] div;
    logic [DIV_W-1:0] cnt;
  } sw_st_t;

  sw_st_t s_r, s_nxt;
  logic fast_tick, cur_tick, new_tick, change, old_dead;

  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] code);
    div_mask = (DIV_W'(1) << code) - DIV_W'(1);
  endfunction

  assign fast_tick = bus.run_fast && ((s_r.cnt & div_mask(s_r.div)) == '0);
  assign cur_tick = s_r.on_sub ? (bus.run_sub && bus.sub_tick) : fast_tick;
  assign old_dead = s_r.on_sub ? !bus.run_sub : !bus.run_fast;
  assign change = (bus.want_sub != s_r.on_sub) || (!bus.want_sub && bus.div_code != s_r.div);
  assign new_tick = s_r.on_sub ? (bus.run_sub && bus.sub_tick) : fast_tick;
  assign bus.sys_en = (s_r.state == SW_RUN) && cur_tick;
  assign bus.on_sub = s_r.on_sub;

  always_comb begin
    s_nxt = s_r;
    if (bus.run_fast) begin
      s_nxt.cnt = s_r.cnt + DIV_W'(1);
    end
    case (s_r.state)
      SW_RUN: begin
        if (change) begin
          s_nxt.state = SW_DRAIN;
        end
      end
      SW_DRAIN: begin
        // Old source finishes its period first
        if (cur_tick || old_dead) begin
          s_nxt.on_sub = bus.want_sub;
          s_nxt.div = bus.div_code;
          s_nxt.cnt = '0;
          s_nxt.state = SW_ARM;
        end
      end
      SW_ARM: begin
        // New source must be stable and ticking
        if (new_tick) begin
          s_nxt.state = SW_RUN;
        end
      end
      default: s_nxt.state = SW_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  chk_sub_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    bus.sys_en && s_r.on_sub |-> bus.run_sub) else $error("sub tick while sub unstable");
endmodule // clk_switch

// ===== rtl/osc_ctrl.sv
// Local design decisions: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
module osc_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire logic wdt_enabled,
  input wire logic wdt_timeout,
  input wire logic wdt_clear_cmd,
  input wire logic sub_clk_pin,
  output logic int_fast_rc_on,
  output logic [1:0] int_fast_rc_freq,
  output logic fast_crystal_on,
  output logic fast_crystal_drive_mode,
  output logic slow_crystal_on,
  output logic int_slow_rc_on,
  output logic fast_clk_run,
  output logic sub_clk_run,
  output logic sys_clk_en,
  output logic cpu_halted,
  output logic wdt_counter_clear,
  output osc_pkg::mode_t power_mode
);
  import osc_pkg::*;

  typedef struct packed {
    logic [2:0] sel;
    logic fast_source_select;
    logic sub_source_select;
    logic fid;
    logic sid;
    logic [1:0] rc_freq;
    logic rc_en;
    logic xt_mode;
    logic xt_en;
    logic lx_en;
    logic power_down_flag;
    logic to;
    mode_t mode;
    logic [2:0] sy;
    logic lvl;
    logic lvl_d;
    logic wr_pend;
    logic [ADDR_W-1:0] waddr;
    logic [31:0] rdata;
    logic [N_OSC-1:0] on_d;
    logic [N_OSC-1:0] stable;
    logic [N_OSC-1:0][CNT_W-1:0] cnt;
    logic wdt_clr;
  } st_t;

  st_t s_r, s_nxt;
  logic ap, fast_alive, sub_alive, fast_stable, sub_stable, halt_go;
  logic [N_OSC-1:0] on_now;
  logic restart_rc;

  clk_sel_if csw ();

  clk_switch u_switch (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(csw.sw)
  );

  function automatic mode_t halt_mode(input logic fid, input logic sid);
    case ({fid, sid})
      2'b00: halt_mode = MODE_SLEEP;
      2'b01: halt_mode = MODE_IDLE0;
      2'b11: halt_mode = MODE_IDLE1;
      default: halt_mode = MODE_IDLE2;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input st_t s, input logic [ADDR_W-1:0] a,
                                           input mode_t m);
    logic [31:0] w;
    w = '0;
    case (a)
      SCC_OFF: begin
        w[SEL_LSB +: SEL_W] = s.sel;
        w[FHS_B] = s.fast_source_select;
        w[FSS_B] = s.sub_source_select;
        w[FHID_B] = s.fid;
        w[FSID_B] = s.sid;
      end
      RC_OFF: begin
        w[RC_FREQ_LSB +: RC_FREQ_W] = s.rc_freq;
        w[RC_FLAG_B] = s.stable[OSC_RC];
        w[RC_EN_B] = s.rc_en;
      end
      HX_OFF: begin
        // Upper bits stay zero
        w[HX_MODE_B] = s.xt_mode;
        w[HX_FLAG_B] = s.stable[OSC_HX];
        w[HX_EN_B] = s.xt_en;
      end
      LX_OFF: begin
        w[LX_FLAG_B] = s.stable[OSC_LX];
        w[LX_EN_B] = s.lx_en;
      end
      ST_OFF: begin
        w[PDF_B] = s.power_down_flag;
        w[TO_B] = s.to;
        w[MODE_LSB +: 3] = m;
      end
      default: w = '0;
    endcase
    rd_word = w;
  endfunction

  // Bus slave, zero wait states
  assign ap = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;

  // Oscillators alive per mode and idle bits
  assign fast_alive = (s_r.mode == MODE_FAST) || (s_r.mode == MODE_IDLE1)
                      || (s_r.mode == MODE_IDLE2);
  assign sub_alive = (s_r.mode == MODE_FAST) || (s_r.mode == MODE_IDLE0)
                     || (s_r.mode == MODE_IDLE1);
  assign on_now[OSC_RC] = s_r.rc_en && fast_alive;
  assign on_now[OSC_HX] = s_r.xt_en && fast_alive;
  assign on_now[OSC_LX] = s_r.lx_en && sub_alive;
  assign int_slow_rc_on = sub_alive || wdt_enabled;
  assign fast_stable = s_r.fast_source_select ? s_r.stable[OSC_HX] : s_r.stable[OSC_RC];
  assign sub_stable = s_r.sub_source_select ? s_r.stable[OSC_LX] : int_slow_rc_on;
  assign fast_clk_run = fast_alive && fast_stable;
  assign sub_clk_run = sub_alive && sub_stable;

  assign int_fast_rc_on = on_now[OSC_RC];
  assign int_fast_rc_freq = s_r.rc_freq;
  assign fast_crystal_on = on_now[OSC_HX];
  assign fast_crystal_drive_mode = s_r.xt_mode;
  assign slow_crystal_on = on_now[OSC_LX];
  assign cpu_halted = (s_r.mode != MODE_FAST);
  assign wdt_counter_clear = s_r.wdt_clr;
  assign power_mode = (s_r.mode == MODE_FAST && csw.on_sub) ? MODE_SLOW : s_r.mode;

  // Clock switch hookup
  assign csw.want_sub = (s_r.sel == SEL_SUB);
  assign csw.div_code = s_r.sel;
  assign csw.sub_tick = s_r.lvl && !s_r.lvl_d;
  assign csw.run_fast = fast_clk_run;
  assign csw.run_sub = sub_clk_run;
  // CPU halted means no system clock
  assign sys_clk_en = csw.sys_en && (s_r.mode == MODE_FAST);

  assign halt_go = halt_req && (s_r.mode == MODE_FAST);

  always_comb begin
    s_nxt = s_r;
    restart_rc = 1'b0;
    s_nxt.wdt_clr = 1'b0;
    // Sub clock pin synchroniser and filter
    s_nxt.sy = {s_r.sy[1:0], sub_clk_pin};
    if (s_r.sy[1] == s_r.sy[2]) begin
      s_nxt.lvl = s_r.sy[2];
    end
    s_nxt.lvl_d = s_r.lvl;
    // Address phase capture
    s_nxt.wr_pend = ap && hwrite;
    if (ap) begin
      s_nxt.waddr = haddr[ADDR_W-1:0];
    end
    s_nxt.rdata = (ap && !hwrite) ? rd_word(s_r, haddr[ADDR_W-1:0], power_mode) : '0;
    // Data phase write
    if (s_r.wr_pend) begin
      case (s_r.waddr)
        SCC_OFF: begin
          s_nxt.sel = hwdata[SEL_LSB +: SEL_W];
          s_nxt.fast_source_select = hwdata[FHS_B];
          s_nxt.sub_source_select = hwdata[FSS_B];
          s_nxt.fid = hwdata[FHID_B];
          s_nxt.sid = hwdata[FSID_B];
        end
        RC_OFF: begin
          restart_rc = (hwdata[RC_FREQ_LSB +: RC_FREQ_W] != s_r.rc_freq);
          s_nxt.rc_freq = hwdata[RC_FREQ_LSB +: RC_FREQ_W];
          s_nxt.rc_en = hwdata[RC_EN_B];
        end
        HX_OFF: begin
          // Mode locked while crystal enabled
          if (!s_r.xt_en) begin
            s_nxt.xt_mode = hwdata[HX_MODE_B];
          end
          s_nxt.xt_en = hwdata[HX_EN_B];
        end
        LX_OFF: begin
          s_nxt.lx_en = hwdata[LX_EN_B];
        end
        default: s_nxt.rc_freq = s_r.rc_freq;
      endcase
    end
    // Power flags; events win over clears
    if (wdt_clear_cmd) begin
      s_nxt.power_down_flag = 1'b0;
    end
    case (s_r.mode)
      MODE_FAST: begin
        if (halt_go) begin
          // Mode, clocks and power flags change; all register settings are held
          s_nxt.mode = halt_mode(s_r.fid, s_r.sid);
          s_nxt.power_down_flag = 1'b1;
          s_nxt.to = 1'b0;
          s_nxt.wdt_clr = 1'b1;
        end
      end
      default: begin
        if (wake_req || wdt_timeout) begin
          s_nxt.mode = MODE_FAST;
        end
      end
    endcase
    if (wdt_timeout) begin
      s_nxt.to = 1'b1;
    end
    // Settle timers
    s_nxt.on_d = on_now;
    for (int i = 0; i < N_OSC; i++) begin
      if (!on_now[i] || !s_r.on_d[i] || (i == OSC_RC && restart_rc)) begin
        s_nxt.cnt[i] = '0;
        s_nxt.stable[i] = 1'b0;
      end else if (!s_r.stable[i]) begin
        s_nxt.cnt[i] = s_r.cnt[i] + CNT_W'(1);
        if (s_r.cnt[i] == SETTLE_CYC[i] - CNT_W'(1)) begin
          s_nxt.cnt[i] = s_r.cnt[i];
          s_nxt.stable[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.sel <= SCC_RST[SEL_LSB +: SEL_W];
      s_r.rc_en <= RC_RST[RC_EN_B];
      s_r.xt_en <= HX_RST[HX_EN_B];
      s_r.lx_en <= LX_RST[LX_EN_B];
      s_r.mode <= MODE_FAST;
    end else begin
      s_r <= s_nxt;
    end
  end

  default clocking dc @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_rc_restart: assert property (s_r.wr_pend && s_r.waddr == RC_OFF
    && hwdata[RC_FREQ_LSB +: RC_FREQ_W] != s_r.rc_freq |=> !s_r.stable[OSC_RC])
    else $error("fast rc flag not cleared on frequency change");
  chk_rc_enable: assert property (s_r.wr_pend && s_r.waddr == RC_OFF && hwdata[RC_EN_B]
    && fast_alive && !halt_go |=> int_fast_rc_on) else $error("fast rc not enabled");
  chk_hx_mode_lock: assert property (s_r.wr_pend && s_r.waddr == HX_OFF && s_r.xt_en
    |=> $stable(fast_crystal_drive_mode)) else $error("drive mode changed while on");
  chk_hx_mode_write: assert property (s_r.wr_pend && s_r.waddr == HX_OFF && !s_r.xt_en
    |=> fast_crystal_drive_mode == $past(hwdata[HX_MODE_B])) else $error("drive mode lost");
  chk_hx_settle: assert property ($rose(s_r.stable[OSC_HX]) |-> $past(fast_crystal_on)
    && s_r.cnt[OSC_HX] == HX_CYC - CNT_W'(1)) else $error("fast crystal flag early");
  chk_hx_off_flag: assert property (!fast_crystal_on |=> !s_r.stable[OSC_HX])
    else $error("fast crystal flag set while off");
  chk_lx_settle: assert property ($rose(s_r.stable[OSC_LX]) |-> $past(slow_crystal_on)
    && s_r.cnt[OSC_LX] == LX_CYC - CNT_W'(1)) else $error("slow crystal flag early");
  chk_rsvd_zero: assert property (ap && !hwrite && haddr[ADDR_W-1:0] == HX_OFF
    |=> hrdata[31:3] == '0) else $error("reserved bits not zero");
  chk_sub_entry: assert property ($rose(csw.on_sub) |-> $past(s_r.sel) == SEL_SUB)
    else $error("sub clock taken without code 111");
  chk_halt_mode: assert property (halt_go |=> s_r.mode == halt_mode($past(s_r.fid),
    $past(s_r.sid))) else $error("wrong low power mode");
  chk_sleep_stop: assert property (s_r.mode == MODE_SLEEP |-> !sys_clk_en
    && !fast_clk_run && !sub_clk_run) else $error("clock running in sleep");
  chk_idle0_fast: assert property (s_r.mode == MODE_IDLE0 |-> !int_fast_rc_on
    && !fast_crystal_on) else $error("fast osc on in idle0");
  chk_halt_flags: assert property (halt_go && !wdt_timeout |=> s_r.power_down_flag && !s_r.to
    && wdt_counter_clear ##1 !wdt_counter_clear) else $error("halt flags wrong");

  cov_idle1: cover property (halt_go && s_r.fid && s_r.sid);
  cov_slow: cover property ($rose(csw.on_sub));
  cov_wake: cover property (s_r.mode == MODE_SLEEP ##1 s_r.mode == MODE_FAST);
endmodule // osc_ctrl

// ===== tb/tb_osc_ctrl.sv
`timescale 1ns/10ps
module tb_osc_ctrl;
  import osc_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, int_fast_rc_freq;
  logic [2:0] hsize;
  logic halt_req, wake_req, wdt_enabled, wdt_timeout, wdt_clear_cmd, sub_clk_pin;
  logic int_fast_rc_on, fast_crystal_on, fast_crystal_drive_mode, slow_crystal_on;
  logic int_slow_rc_on, fast_clk_run, sub_clk_run, sys_clk_en, cpu_halted;
  logic wdt_counter_clear;
  mode_t power_mode;
  mode_t em;
  int miscompares, comparisons, c, k;
  logic [7:0] rd;
  logic [1:0] b;
  row_t rows[8];

  assign hready = hreadyout;

  osc_ctrl i_osc_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .halt_req, .wake_req, .wdt_enabled,
    .wdt_timeout, .wdt_clear_cmd, .sub_clk_pin, .int_fast_rc_on, .int_fast_rc_freq,
    .fast_crystal_on, .fast_crystal_drive_mode, .slow_crystal_on, .int_slow_rc_on,
    .fast_clk_run, .sub_clk_run, .sys_clk_en, .cpu_halted, .wdt_counter_clear,
    .power_mode);

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Raw sub clock, unrelated in phase to hclk
  initial begin
    sub_clk_pin = 1'b0;
    forever #61 sub_clk_pin = ~sub_clk_pin;
  end

  task automatic stop_test();
    $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  // One single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    hsize <= 3'h2;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    r = hrdata[7:0];
    chk(32'(hresp), 32'h0, "response not okay");
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
    bus(1'b0, a, 8'h00, rd);
    chk(32'(rd), 32'(e), m);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic cnt(output int n);
    n = 0;
    repeat (256) begin
      @(posedge hclk);
      if (sys_clk_en === 1'b1) n++;
    end
  endtask

  // One-cycle strobe: 0 time-out, 1 halt, 2 wake, 3 watchdog clear
  task automatic pulse(input int n);
    case (n)
      0: wdt_timeout <= 1'b1;
      1: halt_req <= 1'b1;
      2: wake_req <= 1'b1;
      default: wdt_clear_cmd <= 1'b1;
    endcase
    @(posedge hclk);
    wdt_timeout <= 1'b0;
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    wdt_clear_cmd <= 1'b0;
  endtask

  initial begin
    repeat (50000) @(posedge hclk);
    miscompares++;
    stop_test();
  end

  initial begin
    rows = '{
      '{SCC_OFF, 8'h7F, 8'h6F},
      '{SCC_OFF, 8'h00, 8'h00},
      '{HX_OFF, 8'hFC, 8'h04},
      '{HX_OFF, 8'h00, 8'h00},
      '{LX_OFF, 8'hFE, 8'h00},
      '{8'h20, 8'hFF, 8'h00},
      '{ST_OFF, 8'hFF, 8'h00},
      '{RC_OFF, 8'h0D, 8'h0D}
    };
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    halt_req = 1'b0;
    wake_req = 1'b0;
    wdt_enabled = 1'b0;
    wdt_timeout = 1'b0;
    wdt_clear_cmd = 1'b0;
    miscompares = 0;
    comparisons = 0;
    repeat (20) @(posedge hclk);
    chk(32'(int_fast_rc_on), 32'h1, "rc enable reset");
    chk(32'(fast_crystal_on), 32'h0, "fast crystal reset");
    chk(32'(slow_crystal_on), 32'h0, "slow crystal reset");
    chk(32'(power_mode), 32'(MODE_FAST), "mode reset");
    chk(32'(cpu_halted), 32'h0, "halted reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(SCC_OFF, 8'h00, "scc reset");
    rdc(HX_OFF, 8'h00, "fast crystal reg reset");
    rdc(LX_OFF, 8'h00, "slow crystal reg reset");
    cyc(int'(RC_CYC) + 20);
    rdc(RC_OFF, 8'h03, "rc settled after reset");
    // Ordinary register rows
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdc(rows[i].a, rows[i].e, "register row");
    end
    wr(RC_OFF, 8'h00);
    #1;
    chk(32'(int_fast_rc_on), 32'h0, "rc off");
    wr(RC_OFF, 8'h01);
    rdc(RC_OFF, 8'h01, "rc flag cleared on enable");
    cyc(int'(RC_CYC) + 20);
    rdc(RC_OFF, 8'h03, "rc flag set");
    // Fast crystal: mode first, then enable, then locked mode
    wr(HX_OFF, 8'h04);
    wr(HX_OFF, 8'h05);
    rdc(HX_OFF, 8'h05, "hx flag cleared");
    chk(32'(fast_crystal_on), 32'h1, "hx on");
    wr(HX_OFF, 8'h01);
    rdc(HX_OFF, 8'h05, "drive mode locked");
    chk(32'(fast_crystal_drive_mode), 32'h1, "drive mode pin");
    cyc(int'(HX_CYC) - 40);
    rdc(HX_OFF, 8'h05, "hx flag early");
    cyc(50);
    rdc(HX_OFF, 8'h07, "hx flag set");
    wr(HX_OFF, 8'h00);
    wr(HX_OFF, 8'h00);
    rdc(HX_OFF, 8'h00, "drive mode free when off");
    // Slow crystal settle
    wr(LX_OFF, 8'h01);
    rdc(LX_OFF, 8'h01, "lx flag cleared");
    chk(32'(slow_crystal_on), 32'h1, "lx on");
    cyc(int'(LX_CYC) - 30);
    rdc(LX_OFF, 8'h01, "lx flag early");
    cyc(50);
    rdc(LX_OFF, 8'h03, "lx flag set");
    // Divider codes 000 to 110
    for (k = 0; k < 7; k++) begin
      wr(SCC_OFF, {3'(k), 5'h00});
      cyc(100);
      cnt(c);
      chk(32'(c >= (256 >> k) - 1 && c <= (256 >> k) + 1), 32'h1, "divide rate");
    end
    // Sub clock from slow RC, period about 15.25 cycles
    wr(SCC_OFF, 8'hE0);
    cyc(100);
    chk(32'(power_mode), 32'(MODE_SLOW), "slow mode");
    cnt(c);
    chk(32'(c >= 15 && c <= 18), 32'h1, "sub clock rate");
    wr(SCC_OFF, 8'h00);
    cyc(100);
    chk(32'(power_mode), 32'(MODE_FAST), "back to fast");
    // HALT with each pair of idle bits
    for (k = 0; k < 4; k++) begin
      b = 2'(k);
      em = (b == 2'h0) ? MODE_SLEEP : (b == 2'h1) ? MODE_IDLE0 :
           (b == 2'h3) ? MODE_IDLE1 : MODE_IDLE2;
      wr(SCC_OFF, {6'h00, b});
      pulse(0);
      pulse(1);
      #1;
      chk(32'(power_mode), 32'(em), "halt mode");
      chk(32'(cpu_halted), 32'h1, "cpu halted");
      chk(32'(wdt_counter_clear), 32'h1, "wdt clear pulse");
      chk(32'(sys_clk_en), 32'h0, "system clock stopped");
      chk(32'(fast_clk_run), 32'(b[1]), "fast clock in halt");
      chk(32'(sub_clk_run), 32'(b[0]), "sub clock in halt");
      @(posedge hclk);
      #1;
      chk(32'(wdt_counter_clear), 32'h0, "wdt clear one cycle");
      rdc(ST_OFF, {1'b0, em, 4'h1}, "status in halt");
      rdc(SCC_OFF, {6'h00, b}, "registers kept");
      pulse(2);
      #1;
      chk(32'(power_mode), 32'(MODE_FAST), "woken");
      chk(32'(cpu_halted), 32'h0, "cpu running");
      pulse(3);
      rdc(ST_OFF, 8'h00, "flags cleared");
      // Fast RC was stopped: wait for its flag before relying on it
      if (!b[1]) begin
        rdc(RC_OFF, 8'h01, "fast rc restarting");
        cyc(int'(RC_CYC) + 20);
        rdc(RC_OFF, 8'h03, "fast rc usable again");
      end
    end
    stop_test();
  end
endmodule // tb_osc_ctrl
